// ==== rrcdc_top.sv ====
// reset release sequencer and clock-control register bank.
// assumes clock is the internal fast base clock, sys_rst is the
// power-on (cold) reset, and all request inputs are synchronous.
`timescale 1ns/1ns
module rrcdc_top #(
   parameter int PIN_CYCLES = rrcdc_pkg::PIN_RELEASE_CYCLES,
   parameter int POR_CYCLES = rrcdc_pkg::POR_RELEASE_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic        reset_pin_n,
   input  wire logic        lvd_reset_req,
   input  wire logic        watchdog_reset_req,
   input  wire logic        core_system_reset_request,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output      logic [31:0] reg_rdata,
   output      logic        internal_reset,
   output      logic        gear_clock_enable,
   output      logic        periph_clock_enable,
   output      logic        prescaler_clock_enable,
   output      logic        osc_external_sel,
   output      logic        pll_enable,
   output      logic        pll_select,
   output      logic [2:0]  standby_mode,
   output      logic        flash_security_bit,
   output      logic [2:0]  debug_unit_keep
);

   localparam int CW = rrcdc_pkg::CNT_W;

   typedef struct packed {
      rrcdc_pkg::rrcdc_state_t st;
      logic [CW-1:0]           cnt;
      logic                    int_rst;
      logic [31:0]             sysc;
      logic [31:0]             osc;
      logic [31:0]             stby;
      logic [31:0]             pll;
      logic [31:0]             prot;
      logic [4:0]              flags;
      logic [3:0]              retained;
      logic [31:0]             rdata;
      logic                    periph_en;
   } rrcdc_top_state_t;

   localparam rrcdc_top_state_t RST_STATE = '{
      st       : rrcdc_pkg::RRCDC_ST_POR_WAIT,
      cnt      : CW'(POR_CYCLES - 1),
      int_rst  : 1'b1,
      sysc     : rrcdc_pkg::RST_SYSTEM_CLOCK_CONFIG,
      osc      : rrcdc_pkg::RST_OSCILLATOR_CONTROL,
      stby     : rrcdc_pkg::RST_STANDBY_CONTROL,
      pll      : rrcdc_pkg::RST_PLL_SOURCE_SELECT,
      prot     : rrcdc_pkg::RST_WRITE_PROTECT_KEY,
      flags    : rrcdc_pkg::RST_SOURCE_FLAGS,
      retained : rrcdc_pkg::RST_COLD_RETAINED,
      rdata    : 32'h0000_0000,
      periph_en: 1'b0
   };

   rrcdc_top_state_t r;
   rrcdc_top_state_t next_r;

   logic       src_pin;
   logic       src_lvd;
   logic       src_short;
   logic       src_long;
   logic       periph_clock_source_sel;
   logic [2:0] gear_code;
   logic [2:0] prescaler_ratio;
   logic [2:0] gear_log2;
   logic [2:0] prescaler_log2;
   logic       periph_tick;
   logic       wr_hit;

   assign src_pin   = !reset_pin_n;
   assign src_lvd   = lvd_reset_req;
   assign src_short = watchdog_reset_req | core_system_reset_request;
   assign src_long  = src_pin | src_lvd;
   assign wr_hit    = reg_write && !r.int_rst;

   assign periph_clock_source_sel = r.sysc[rrcdc_pkg::SYS_PERIPH_SRC_BIT];
   assign gear_code = r.sysc[rrcdc_pkg::SYS_GEAR_LSB +: 3];
   assign prescaler_ratio = r.sysc[rrcdc_pkg::SYS_PRESCALER_LSB +: 3];

   // reserved gear codes fall back to undivided; no guard beyond that
   always_comb begin
      case (gear_code)
         3'h4:    gear_log2 = 3'h1;
         3'h5:    gear_log2 = 3'h2;
         3'h6:    gear_log2 = 3'h3;
         3'h7:    gear_log2 = 3'h4;
         default: gear_log2 = 3'h0;
      endcase
   end

   // reserved prescaler codes clamp to the largest ratio
   assign prescaler_log2 = (prescaler_ratio > 3'h5) ? 3'h5
                                                    : prescaler_ratio;

   // fast source keeps the peripheral rate free of the gear setting
   assign periph_tick = periph_clock_source_sel ? 1'b1
                                                : gear_clock_enable;

   always_comb begin
      next_r           = r;
      next_r.rdata     = 32'h0000_0000;

      // release sequencer
      case (r.st)
         rrcdc_pkg::RRCDC_ST_RUN: begin
            if (src_long) begin
               next_r.st = rrcdc_pkg::RRCDC_ST_PIN_HELD;
            end else if (src_short) begin
               next_r.st  = rrcdc_pkg::RRCDC_ST_SHORT_WAIT;
               next_r.cnt = CW'(rrcdc_pkg::SHORT_RELEASE_CYCLES - 1);
            end
         end
         rrcdc_pkg::RRCDC_ST_PIN_HELD: begin
            // held as long as the supervisor keeps the pin low or lvd_reset_req stays high
            if (!src_long) begin
               next_r.st  = rrcdc_pkg::RRCDC_ST_PIN_WAIT;
               next_r.cnt = CW'(PIN_CYCLES - 1);
            end
         end
         rrcdc_pkg::RRCDC_ST_POR_WAIT,
         rrcdc_pkg::RRCDC_ST_PIN_WAIT,
         rrcdc_pkg::RRCDC_ST_SHORT_WAIT: begin
            // short requests during a wait are absorbed by it
            if (src_long) begin
               next_r.st = rrcdc_pkg::RRCDC_ST_PIN_HELD;
            end else if (r.cnt == '0) begin
               next_r.st = rrcdc_pkg::RRCDC_ST_RUN;
            end else begin
               next_r.cnt = r.cnt - CW'(1);
            end
         end
         default: begin
            next_r.st = rrcdc_pkg::RRCDC_ST_PIN_HELD;
         end
      endcase
      next_r.int_rst = (next_r.st != rrcdc_pkg::RRCDC_ST_RUN);

      // source flags: software write-one clears, a new event wins
      if (wr_hit && reg_addr == rrcdc_pkg::OFS_RESET_SOURCE_FLAGS) begin
         next_r.flags = r.flags & ~reg_wdata[4:0];
      end
      if (src_pin) begin
         next_r.flags[rrcdc_pkg::SRC_PIN] = 1'b1;
      end
      if (src_lvd) begin
         next_r.flags[rrcdc_pkg::SRC_LVD] = 1'b1;
      end
      if (watchdog_reset_req) begin
         next_r.flags[rrcdc_pkg::SRC_WATCHDOG] = 1'b1;
      end
      if (core_system_reset_request) begin
         next_r.flags[rrcdc_pkg::SRC_CORE] = 1'b1;
      end

      // register writes; any warm reset reloads the control bank
      if (r.int_rst) begin
         next_r.sysc = rrcdc_pkg::RST_SYSTEM_CLOCK_CONFIG;
         next_r.osc  = rrcdc_pkg::RST_OSCILLATOR_CONTROL;
         next_r.stby = rrcdc_pkg::RST_STANDBY_CONTROL;
         next_r.pll  = rrcdc_pkg::RST_PLL_SOURCE_SELECT;
         next_r.prot = rrcdc_pkg::RST_WRITE_PROTECT_KEY;
      end else if (reg_write) begin
         if (reg_addr == rrcdc_pkg::OFS_SYSTEM_CLOCK_CONFIG) begin
            next_r.sysc = reg_wdata & rrcdc_pkg::MASK_SYSTEM_CLOCK_CONFIG;
         end else if (reg_addr == rrcdc_pkg::OFS_OSCILLATOR_CONTROL) begin
            next_r.osc = reg_wdata & rrcdc_pkg::MASK_OSCILLATOR_CONTROL;
         end else if (reg_addr == rrcdc_pkg::OFS_STANDBY_CONTROL) begin
            next_r.stby = reg_wdata & rrcdc_pkg::MASK_STANDBY_CONTROL;
         end else if (reg_addr == rrcdc_pkg::OFS_PLL_SOURCE_SELECT) begin
            next_r.pll = reg_wdata & rrcdc_pkg::MASK_PLL_SOURCE_SELECT;
         end else if (reg_addr == rrcdc_pkg::OFS_WRITE_PROTECT_KEY) begin
            next_r.prot = reg_wdata & rrcdc_pkg::MASK_WRITE_PROTECT_KEY;
         end else if (reg_addr == rrcdc_pkg::OFS_COLD_RETAINED) begin
            next_r.retained = reg_wdata[3:0];
         end
      end

      // register reads, answered in the next cycle
      if (reg_read) begin
         if (reg_addr == rrcdc_pkg::OFS_SYSTEM_CLOCK_CONFIG) begin
            next_r.rdata = r.sysc & rrcdc_pkg::MASK_SYSTEM_CLOCK_CONFIG;
         end else if (reg_addr == rrcdc_pkg::OFS_OSCILLATOR_CONTROL) begin
            next_r.rdata = r.osc & rrcdc_pkg::MASK_OSCILLATOR_CONTROL;
            next_r.rdata[rrcdc_pkg::OSC_STATUS_BIT] =
               r.osc[rrcdc_pkg::OSC_EXT_SEL_BIT];
         end else if (reg_addr == rrcdc_pkg::OFS_STANDBY_CONTROL) begin
            next_r.rdata = r.stby;
         end else if (reg_addr == rrcdc_pkg::OFS_PLL_SOURCE_SELECT) begin
            next_r.rdata = r.pll;
         end else if (reg_addr == rrcdc_pkg::OFS_WRITE_PROTECT_KEY) begin
            next_r.rdata = r.prot;
         end else if (reg_addr == rrcdc_pkg::OFS_RESET_SOURCE_FLAGS) begin
            next_r.rdata = {27'h0, r.flags};
         end else if (reg_addr == rrcdc_pkg::OFS_COLD_RETAINED) begin
            next_r.rdata = {28'h0000000, r.retained};
         end
      end

      next_r.periph_en = periph_tick && !r.int_rst;
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         r <= RST_STATE;
      end else begin
         r <= next_r;
      end
   end

   rrcdc_divider #(
      .CW(5)
   ) u_gear_div (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .clear     (r.int_rst),
      .tick      (1'b1),
      .log2_ratio(gear_log2),
      .pulse     (gear_clock_enable)
   );

   rrcdc_divider #(
      .CW(5)
   ) u_presc_div (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .clear     (r.int_rst),
      .tick      (periph_tick),
      .log2_ratio(prescaler_log2),
      .pulse     (prescaler_clock_enable)
   );

   assign reg_rdata           = r.rdata;
   assign internal_reset      = r.int_rst;
   assign periph_clock_enable = r.periph_en;
   assign osc_external_sel    = r.osc[rrcdc_pkg::OSC_EXT_SEL_BIT];
   assign pll_enable          = r.osc[rrcdc_pkg::OSC_PLL_ON_BIT];
   assign pll_select          = r.pll[0];
   assign standby_mode        = r.stby[2:0];
   assign flash_security_bit  = r.retained[0];
   assign debug_unit_keep     = r.retained[3:1];

   a_short_load: assert property (@(posedge clock) disable iff (sys_rst)
      (r.st == rrcdc_pkg::RRCDC_ST_RUN && src_short && !src_long)
      |=> (r.st == rrcdc_pkg::RRCDC_ST_SHORT_WAIT && r.cnt == CW'(29)
           && internal_reset))
      else $error("short reset not loaded with 30 cycles");

   a_short_release: assert property (@(posedge clock)
      disable iff (sys_rst)
      (r.st == rrcdc_pkg::RRCDC_ST_SHORT_WAIT && r.cnt == CW'(1)
       && !src_long) ##1 !src_long
      |=> (!internal_reset && r.st == rrcdc_pkg::RRCDC_ST_RUN))
      else $error("short reset not released on count end");

   a_pin_held: assert property (@(posedge clock) disable iff (sys_rst)
      src_long |=> (r.st == rrcdc_pkg::RRCDC_ST_PIN_HELD && internal_reset))
      else $error("pin or lvd request did not hold reset");

   a_pin_load: assert property (@(posedge clock) disable iff (sys_rst)
      (r.st == rrcdc_pkg::RRCDC_ST_PIN_HELD && !src_long)
      |=> (r.st == rrcdc_pkg::RRCDC_ST_PIN_WAIT
           && r.cnt == CW'(PIN_CYCLES - 1)))
      else $error("pin release count not loaded");

   a_wait_count: assert property (@(posedge clock) disable iff (sys_rst)
      (r.st != rrcdc_pkg::RRCDC_ST_RUN
       && r.st != rrcdc_pkg::RRCDC_ST_PIN_HELD
       && r.cnt != '0 && !src_long)
      |=> (r.cnt == $past(r.cnt) - CW'(1) && internal_reset))
      else $error("release counter did not step down");

   a_gear_half: assert property (@(posedge clock) disable iff (sys_rst)
      (gear_clock_enable && gear_code == 3'h4 && !reg_write && !r.int_rst)
      |=> !gear_clock_enable ##1 (gear_clock_enable || reg_write
                                  || r.int_rst || $past(reg_write)))
      else $error("gear by two does not pulse every second cycle");

   a_fast_src: assert property (@(posedge clock) disable iff (sys_rst)
      (periph_clock_source_sel && !r.int_rst) |=> periph_clock_enable)
      else $error("fast peripheral source not every cycle");

   a_sysc_read: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_read && reg_addr == rrcdc_pkg::OFS_SYSTEM_CLOCK_CONFIG)
      |=> ((reg_rdata & ~rrcdc_pkg::MASK_SYSTEM_CLOCK_CONFIG) == '0))
      else $error("unused system register bits read nonzero");

   a_warm_clear: assert property (@(posedge clock) disable iff (sys_rst)
      internal_reset |=> (r.sysc == rrcdc_pkg::RST_SYSTEM_CLOCK_CONFIG
                          && !osc_external_sel))
      else $error("warm reset left control registers set");

   a_cold_keep: assert property (@(posedge clock) disable iff (sys_rst)
      (internal_reset && !reg_write) |=> $stable(r.retained))
      else $error("retained bits changed on warm reset");

   a_rdata_zero: assert property (@(posedge clock) disable iff (sys_rst)
      !reg_read |=> (reg_rdata == 32'h0000_0000))
      else $error("read data not zero outside the answer cycle");

   a_periph_gear: assert property (@(posedge clock)
      disable iff (sys_rst)
      (!periph_clock_source_sel && !r.int_rst)
      |=> (periph_clock_enable == $past(gear_clock_enable)))
      else $error("peripheral enable does not follow the gear");

   a_presc_tick: assert property (@(posedge clock)
      disable iff (sys_rst)
      prescaler_clock_enable |-> $past(periph_tick))
      else $error("prescaler pulse without a peripheral tick");

   a_pin_flag: assert property (@(posedge clock) disable iff (sys_rst)
      src_pin |=> r.flags[rrcdc_pkg::SRC_PIN])
      else $error("pin reset not recorded in the source flags");

   a_watchdog_flag: assert property (@(posedge clock)
      disable iff (sys_rst)
      watchdog_reset_req |=> r.flags[rrcdc_pkg::SRC_WATCHDOG])
      else $error("watchdog reset not recorded in the source flags");

endmodule

// ==== rrcdc_pkg.sv ====
// constants, field layouts and state codes for the reset release and
// clock divider control block; shared by the top and the test bench.
package rrcdc_pkg;

   // clock rate of the fast base clock
   localparam real CLOCK_MHZ = 100.0;

   // release times, in their own units
   localparam real PIN_RELEASE_MS    = 0.8;
   localparam real POR_RELEASE_MS    = 1.8;
   localparam int  SHORT_RELEASE_CLK = 30;
   localparam int  PIN_MIN_LOW_CLK   = 12;

   localparam int PIN_RELEASE_CYCLES =
      $rtoi(PIN_RELEASE_MS * CLOCK_MHZ * 1000.0 + 0.5);
   localparam int POR_RELEASE_CYCLES =
      $rtoi(POR_RELEASE_MS * CLOCK_MHZ * 1000.0 + 0.5);
   localparam int SHORT_RELEASE_CYCLES = SHORT_RELEASE_CLK;

   localparam int CNT_W = 18;

   // register offsets
   localparam logic [7:0] OFS_SYSTEM_CLOCK_CONFIG = 8'h00;
   localparam logic [7:0] OFS_OSCILLATOR_CONTROL  = 8'h04;
   localparam logic [7:0] OFS_STANDBY_CONTROL     = 8'h08;
   localparam logic [7:0] OFS_PLL_SOURCE_SELECT   = 8'h0C;
   localparam logic [7:0] OFS_WRITE_PROTECT_KEY   = 8'h3C;
   localparam logic [7:0] OFS_RESET_SOURCE_FLAGS  = 8'h40;
   localparam logic [7:0] OFS_COLD_RETAINED       = 8'h44;

   // reset values
   localparam logic [31:0] RST_SYSTEM_CLOCK_CONFIG = 32'h0001_0000;
   localparam logic [31:0] RST_OSCILLATOR_CONTROL  = 32'h8001_0030;
   localparam logic [31:0] RST_STANDBY_CONTROL     = 32'h0000_0003;
   localparam logic [31:0] RST_PLL_SOURCE_SELECT   = 32'h0000_0000;
   localparam logic [31:0] RST_WRITE_PROTECT_KEY   = 32'h0000_0000;
   localparam logic [4:0]  RST_SOURCE_FLAGS        = 5'h01;
   localparam logic [3:0]  RST_COLD_RETAINED       = 4'h0;

   // bits that hold storage; all others read as zero except the oscillator status bit
   localparam logic [31:0] MASK_SYSTEM_CLOCK_CONFIG = 32'h0013_3707;
   localparam logic [31:0] MASK_OSCILLATOR_CONTROL  = 32'hFFFF_D1FC;
   localparam logic [31:0] MASK_STANDBY_CONTROL     = 32'h0000_0007;
   localparam logic [31:0] MASK_PLL_SOURCE_SELECT   = 32'h0000_0001;
   localparam logic [31:0] MASK_WRITE_PROTECT_KEY   = 32'h0000_00FF;

   // system_clock_config fields
   localparam int SYS_PERIPH_SRC_BIT = 12;
   localparam int SYS_PRESCALER_LSB  = 8;
   localparam int SYS_GEAR_LSB       = 0;

   // oscillator_control fields
   localparam int OSC_EXT_SEL_BIT  = 17;
   localparam int OSC_STATUS_BIT   = 9;
   localparam int OSC_PLL_ON_BIT   = 2;

   // reset source flag positions
   localparam int SRC_POR  = 0;
   localparam int SRC_PIN  = 1;
   localparam int SRC_LVD  = 2;
   localparam int SRC_WATCHDOG = 3;
   localparam int SRC_CORE = 4;

   typedef enum logic [2:0] {
      RRCDC_ST_RUN        = 3'h0,
      RRCDC_ST_POR_WAIT   = 3'h1,
      RRCDC_ST_PIN_HELD   = 3'h2,
      RRCDC_ST_PIN_WAIT   = 3'h3,
      RRCDC_ST_SHORT_WAIT = 3'h4
   } rrcdc_state_t;

endpackage

// ==== rrcdc_divider.sv ====
// enable-pulse divider: one pulse per 2**log2_ratio input ticks.
// assumes one clock; clear is synchronous and wins over tick.
`timescale 1ns/1ns
module rrcdc_divider #(
   parameter int CW = 5
) (
   input  wire logic          clock,
   input  wire logic          sys_rst,
   input  wire logic          clear,
   input  wire logic          tick,
   input  wire logic [2:0]    log2_ratio,
   output      logic          pulse
);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          pulse;
   } rrcdc_div_state_t;

   rrcdc_div_state_t r;
   rrcdc_div_state_t next_r;
   logic [CW-1:0]    mask;

   assign mask  = CW'((6'h01 << log2_ratio) - 6'h01);
   assign pulse = r.pulse;

   always_comb begin
      next_r       = r;
      next_r.pulse = 1'b0;
      if (clear) begin
         next_r.cnt = '0;
      end else if (tick) begin
         next_r.pulse = ((r.cnt & mask) == mask);
         if (r.cnt >= mask) begin
            next_r.cnt = '0;
         end else begin
            next_r.cnt = r.cnt + CW'(1);
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

endmodule

// ==== rrcdc_supervisor.sv ====
// reset supervisor model driving the active-low reset pin.
// assumes one clock; sys_rst stands for the power-up period.
`timescale 1ns/1ns
module rrcdc_supervisor #(
   parameter logic [7:0] MIN_LOW = 8'h0C
) (
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       hold_req,
   input  wire logic [7:0] hold_len,
   output      logic       reset_pin_n
);
   logic [7:0] left;

   // short requests are stretched, a real supervisor never pulses
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         left <= 8'h00;
      end else if (hold_req) begin
         left <= (hold_len < MIN_LOW) ? MIN_LOW : hold_len;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end

   // pin low for the whole power-up period
   assign reset_pin_n = !sys_rst && (left == 8'h00);
endmodule

// ==== rrcdc_top_test.sv ====
// self-checking bench for the reset release and clock divider block.
// assumes shortened release counts; the supervisor model drives the pin.
`timescale 1ns/1ns
module rrcdc_top_test;
   localparam int PIN = 20;
   localparam int POR = 40;
   logic        clock;
   logic        sys_rst;
   logic        reset_pin_n;
   logic        lvd_req;
   logic        watchdog_req;
   logic        core_req;
   logic        hold_req;
   logic [7:0]  hold_len;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_write;
   logic        reg_read;
   logic [31:0] reg_rdata;
   logic        internal_reset;
   logic        gear_en;
   logic        periph_en;
   logic        pre_en;
   logic        osc_ext;
   logic        pll_en;
   logic        pll_sel;
   logic [2:0]  stby;
   logic        fsec;
   logic [2:0]  dbg_keep;
   logic [31:0] rnd;
   logic [31:0] rd;
   logic [31:0] v;
   logic [31:0] wv [5];
   logic [7:0]  adr [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h3C, 8'h20};
   logic [2:0]  gcode [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
   logic [31:0] msk [6] = '{rrcdc_pkg::MASK_SYSTEM_CLOCK_CONFIG,
      rrcdc_pkg::MASK_OSCILLATOR_CONTROL, rrcdc_pkg::MASK_STANDBY_CONTROL,
      rrcdc_pkg::MASK_PLL_SOURCE_SELECT, rrcdc_pkg::MASK_WRITE_PROTECT_KEY,
      32'h00000000};
   logic [31:0] rv [6] = '{32'h00010000, rrcdc_pkg::RST_OSCILLATOR_CONTROL,
      rrcdc_pkg::RST_STANDBY_CONTROL, rrcdc_pkg::RST_PLL_SOURCE_SELECT,
      rrcdc_pkg::RST_WRITE_PROTECT_KEY, 32'h00000000};
   int          failures;
   int          checks_done;
   int          n;
   int          cg;
   int          cp;
   int          cs;

   rrcdc_top #(.PIN_CYCLES(PIN), .POR_CYCLES(POR)) u_dut (
      .clock(clock), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
      .lvd_reset_req(lvd_req), .watchdog_reset_req(watchdog_req),
      .core_system_reset_request(core_req), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .internal_reset(internal_reset),
      .gear_clock_enable(gear_en), .periph_clock_enable(periph_en),
      .prescaler_clock_enable(pre_en), .osc_external_sel(osc_ext),
      .pll_enable(pll_en), .pll_select(pll_sel), .standby_mode(stby),
      .flash_security_bit(fsec), .debug_unit_keep(dbg_keep));

   rrcdc_supervisor u_sup (.clock(clock), .sys_rst(sys_rst),
      .hold_req(hold_req), .hold_len(hold_len), .reset_pin_n(reset_pin_n));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h00400007 : 32'h00000000);
   endfunction

   // pulses seen in w cycles from an enable dividing by 2**l2
   function automatic int expect_pulses(input int w, input int l2);
      return w >> l2;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // release times are approximate, so allow a few cycles of slack
   task automatic near(input int cnt, input int lo);
      check({31'h0, (cnt >= lo && cnt <= lo + 3)}, 32'h1);
   endtask

   task automatic finish_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask

   task automatic rdr(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // counts cycles with internal reset still high
   task automatic held(output int cnt);
      cnt = 0;
      #1;
      while (internal_reset === 1'b1 && cnt < 2000) begin
         cnt++;
         @(posedge clock);
         #1;
      end
      if (cnt >= 2000) begin
         failures++;
         finish_test();
      end
   endtask

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   initial begin
      sys_rst = 1'b1;
      {lvd_req, watchdog_req, core_req, hold_req, reg_write, reg_read} = 6'h00;
      hold_len = 8'h0C;
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
      rnd = 32'h00003D2E;
      failures = 0;
      checks_done = 0;
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      held(n);
      near(n, POR);
      for (int i = 0; i < 6; i++) begin
         rdr(adr[i], rd);
         check(rd, rv[i]);
      end
      check({29'h0, stby}, 32'h3);
      $display("test reset values done");
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         v = rnd;
         if (i == 0) begin
            v[2:0] = gcode[rnd[20:16] % 5];
            v[10:8] = 3'(rnd[15:13] % 6);
            v = (v & ~32'h0013_2000) | 32'h0001_0000;
         end
         if (i == 1) v = v | 32'h00020004;
         wr(adr[i], v);
         if (i < 5) wv[i] = v;
         v = v & msk[i];
         if (i == 1) v[9] = v[17];
         rdr(adr[i], rd);
         check(rd, v);
      end
      check({31'h0, osc_ext}, 32'h1);
      check({31'h0, pll_en}, 32'h1);
      check({31'h0, pll_sel}, {31'h0, wv[3][0]});
      check({29'h0, stby}, {29'h0, wv[2][2:0]});
      $display("test register access done");
      for (int g = 0; g < 5; g++) begin
         for (int p = 0; p < 6; p++) begin
            for (int f = 0; f < 2; f++) begin
               wr(8'h00, 32'h00010000 | (f << 12) | (p << 8) | gcode[g]);
               repeat (40) @(posedge clock);
               {cg, cp, cs} = '0;
               for (int k = 0; k < 512; k++) begin
                  @(posedge clock);
                  #1;
                  cg += int'(gear_en);
                  cp += int'(periph_en);
                  cs += int'(pre_en);
               end
               check(cg, expect_pulses(512, g));
               check(cp, expect_pulses(512, f ? 0 : g));
               check(cs, expect_pulses(512, (f ? 0 : g) + p));
            end
         end
      end
      $display("test clock dividers done");
      for (int s = 0; s < 4; s++) begin
         wr(8'h00, 32'h00011405);
         wr(8'h04, 32'h80030034);
         wr(8'h0C, 32'h00000001);
         wr(8'h44, 32'h0000000F);
         @(posedge clock);
         case (s)
            0: hold_req <= 1'b1;
            1: lvd_req <= 1'b1;
            2: watchdog_req <= 1'b1;
            default: core_req <= 1'b1;
         endcase
         repeat (s == 1 ? 5 : 1) @(posedge clock);
         {lvd_req, watchdog_req, core_req, hold_req} <= 4'h0;
         #1;
         for (int k = 0; k < 300 && reset_pin_n !== 1'b1; k++) begin
            @(posedge clock);
            #1;
         end
         if (reset_pin_n !== 1'b1) begin
            failures++;
            finish_test();
         end
         held(n);
         if (s < 2) near(n, PIN);
         else check(n, 30);
         rdr(8'h00, rd);
         check(rd, 32'h00010000);
         rdr(8'h44, rd);
         check(rd, 32'h0000000F);
         check({28'h0, dbg_keep, fsec}, 32'hF);
         check({30'h0, osc_ext, pll_en}, 32'h0);
         check({31'h0, pll_sel}, 32'h0);
         rdr(8'h40, rd);
         check(rd & (32'h2 << s), 32'h2 << s);
         wr(8'h40, 32'h0000001F);
      end
      $display("test warm resets done");
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      held(n);
      near(n, POR);
      rdr(8'h44, rd);
      check(rd, 32'h00000000);
      check({28'h0, dbg_keep, fsec}, 32'h0);
      rdr(8'h40, rd);
      check(rd, 32'h00000001);
      $display("test cold reset done");
      finish_test();
   end
endmodule
